// [rtl/rcss_consts.svh]
`ifndef RCSS_CONSTS_SVH
`define RCSS_CONSTS_SVH

// register offsets (byte addresses, one word each)
`define RCSS_ADDR_SRC       8'h00
`define RCSS_ADDR_ASSIGN0   8'h04
`define RCSS_ADDR_STATUS    8'h20
`define RCSS_NUM_TERMINALS  7

// status field positions
`define RCSS_STAT_LOCAL     0
`define RCSS_STAT_RUN       1
`define RCSS_STAT_REV       2
`define RCSS_STAT_SEL_IN    3

// reset values
`define RCSS_RST_SRC        2'h0
`define RCSS_RST_ASSIGN     8'h00
`define RCSS_RST_ASSIGN_T5  8'h23
`define RCSS_TERM_T5_INDEX  4

// terminal function code of the remote/local select
`define RCSS_CODE_MODE_SEL  8'h23

// toggle key hold time
`define RCSS_CLK_HZ         40000000
`define RCSS_HOLD_TIME_MS   1000
`define RCSS_HOLD_CYCLES    (`RCSS_HOLD_TIME_MS * (`RCSS_CLK_HZ / 1000))

`endif

// [rtl/rcss_pkg.sv]
package rcss_pkg;

    typedef enum logic [1:0] {
        RCSS_SRC_KEY_TERM_DIR = 2'b00,
        RCSS_SRC_TERMINAL     = 2'b01,
        RCSS_SRC_KEY_FWD      = 2'b10,
        RCSS_SRC_KEY_REV      = 2'b11
    } rcss_src_t;

    typedef enum logic {
        RCSS_MODE_REMOTE = 1'b0,
        RCSS_MODE_LOCAL  = 1'b1
    } rcss_mode_t;

endpackage : rcss_pkg

// [rtl/rcss_term_map.sv]
`timescale 1ns/10ps
`include "rcss_consts.svh"

module rcss_term_map #(
    parameter int N = 7
) (
    input  wire logic [N-1:0]      i_terminal,   // general input terminal levels
    input  wire logic [N-1:0][7:0] i_assign,     // function code of each terminal
    output logic                   o_mode_select // remote/local select level
);
    always_comb begin
        o_mode_select = 1'b0;
        for (int k = 0; k < N; k++) begin
            if (i_assign[k] == `RCSS_CODE_MODE_SEL && i_terminal[k]) begin
                o_mode_select = 1'b1;
            end
        end
    end
endmodule : rcss_term_map

// [rtl/rcss_key_hold.sv]
`timescale 1ns/10ps

module rcss_key_hold #(
    parameter int CYCLES = 40000000
) (
    input  wire logic i_sys_clk,  // system clock
    input  wire logic i_reset,    // synchronous reset, active high
    input  wire logic i_key,      // key level, high while held
    output logic      o_fire      // one pulse per hold of CYCLES cycles
);
    localparam int CW = $clog2(CYCLES + 1);

    generate
        if (CYCLES < 1) begin : g_bad_cycles
            $error("rcss_key_hold: CYCLES must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [CW-1:0] cnt;
    } rcss_hold_t;

    rcss_hold_t st_ff;
    rcss_hold_t nxt_st;

    // fires on the cycle the hold reaches CYCLES, once per press
    assign o_fire = i_key && (st_ff.cnt == CW'(CYCLES - 1));

    always_comb begin
        nxt_st = st_ff;
        if (!i_key) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt != CW'(CYCLES)) begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : rcss_key_hold

// [rtl/rcss_top.sv]
`timescale 1ns/10ps
`include "rcss_consts.svh"

module rcss_top
    import rcss_pkg::*;
#(
    parameter int FW          = 16,                 // frequency word width
    parameter int HOLD_CYCLES = `RCSS_HOLD_CYCLES   // toggle key hold count
) (
    input  wire logic          i_sys_clk,                // system clock, 40 MHz
    input  wire logic          i_reset,                  // synchronous reset, active high
    input  wire logic [7:0]    i_addr,                   // register byte address
    input  wire logic [31:0]   i_wdata,                  // register write data
    input  wire logic          i_wr,                     // register write strobe
    input  wire logic          i_rd,                     // register read strobe
    output logic      [31:0]   o_rdata,                  // read data, cycle after i_rd
    input  wire logic [6:0]    i_general_input_terminal, // five general plus two extra
    input  wire logic          i_forward_run_input,      // forward terminal command
    input  wire logic          i_reverse_run_input,      // reverse terminal command
    input  wire logic          i_run_cmd2_select,        // run command 2/1 select
    input  wire logic          i_link_operation,         // link operation select
    input  wire logic          i_link_run_fwd,           // link forward run command
    input  wire logic          i_link_run_rev,           // link reverse run command
    input  wire logic [FW-1:0] i_remote_freq,            // frequency from remote source
    input  wire logic          i_keypad_run_press,       // keypad run key pulse
    input  wire logic          i_keypad_stop_press,      // keypad stop key pulse
    input  wire logic          i_keypad_freq_wr,         // keypad frequency update pulse
    input  wire logic [FW-1:0] i_keypad_freq,            // keypad frequency value
    input  wire logic          i_opt_fwd_key,            // optional keypad forward pulse
    input  wire logic          i_opt_rev_key,            // optional keypad reverse pulse
    input  wire logic          i_opt_toggle_key,         // optional keypad toggle level
    output logic               o_run_cmd,                // motor run command
    output logic               o_run_reverse,            // direction, high for reverse
    output logic      [FW-1:0] o_freq_cmd,               // frequency command in use
    output logic               o_remote_mode_indicator,  // lit in remote mode
    output logic               o_local_mode_indicator    // lit in local mode
);
    localparam int NT = `RCSS_NUM_TERMINALS;

    generate
        if (FW < 1 || FW > 32) begin : g_bad_fw
            $error("rcss_top: FW must be 1 to 32");
        end
        if (HOLD_CYCLES < 1) begin : g_bad_hold
            $error("rcss_top: HOLD_CYCLES must be at least 1");
        end
    endgenerate

    typedef struct packed {
        rcss_mode_t          mode;
        logic                sel_prev;
        logic                run;
        logic                reverse_run_input;
        logic [FW-1:0]       freq_local;
        logic [FW-1:0]       freq_out;
        rcss_src_t           src;
        logic [NT-1:0][7:0]  assign_code;
        logic [31:0]         rdata;
    } rcss_state_t;

    rcss_state_t st_ff;
    rcss_state_t nxt_st;

    logic sel_in;
    logic toggle_fire;

    // start decision for a keypad run press: bit 1 allowed, bit 0 reverse
    function automatic logic [1:0] key_start(input rcss_src_t src,
                                             input logic fwd_in,
                                             input logic rev_in);
        logic [1:0] r;
        r = 2'b00;
        unique case (src)
            RCSS_SRC_KEY_FWD: r = 2'b10;
            RCSS_SRC_KEY_REV: r = 2'b11;
            RCSS_SRC_KEY_TERM_DIR,
            RCSS_SRC_TERMINAL: r = {fwd_in ^ rev_in, rev_in};
        endcase
        return r;
    endfunction : key_start

    function automatic logic [7:0] word_index(input logic [7:0] a);
        return {2'b00, a[7:2]};
    endfunction : word_index

    rcss_term_map #(
        .N (NT)
    ) u_term_map (
        .i_terminal    (i_general_input_terminal),
        .i_assign      (st_ff.assign_code),
        .o_mode_select (sel_in)
    );

    rcss_key_hold #(
        .CYCLES (HOLD_CYCLES)
    ) u_toggle_hold (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_key     (i_opt_toggle_key),
        .o_fire    (toggle_fire)
    );

    logic       sel_rise;
    logic       sel_fall;
    logic       enter_local;
    logic [1:0] start;

    assign sel_rise    = sel_in && !st_ff.sel_prev;
    assign sel_fall    = !sel_in && st_ff.sel_prev;
    assign enter_local = (nxt_st.mode == RCSS_MODE_LOCAL) && (st_ff.mode == RCSS_MODE_REMOTE);
    assign start       = key_start(st_ff.src, i_forward_run_input, i_reverse_run_input);

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.sel_prev = sel_in;
        nxt_st.rdata    = 32'h0;

        // mode selection
        if (sel_rise) begin
            nxt_st.mode = RCSS_MODE_LOCAL;
        end else if (sel_fall) begin
            nxt_st.mode = RCSS_MODE_REMOTE;
        end else if (toggle_fire && !sel_in) begin
            nxt_st.mode = (st_ff.mode == RCSS_MODE_LOCAL) ? RCSS_MODE_REMOTE
                                                          : RCSS_MODE_LOCAL;
        end

        if (nxt_st.mode == RCSS_MODE_LOCAL && st_ff.mode == RCSS_MODE_REMOTE) begin
            // changeover: inherit frequency, carry the run over unless it conflicts
            nxt_st.freq_local = i_remote_freq;
            if (st_ff.run) begin
                if ((st_ff.src == RCSS_SRC_KEY_FWD && st_ff.reverse_run_input) ||
                    (st_ff.src == RCSS_SRC_KEY_REV && !st_ff.reverse_run_input)) begin
                    nxt_st.run = 1'b0;
                end else begin
                    nxt_st.run = 1'b1;
                end
            end
        end else if (nxt_st.mode != st_ff.mode) begin
            nxt_st.run = st_ff.run;
        end else if (st_ff.mode == RCSS_MODE_LOCAL) begin
            // keypad only, run command 2 select and link ignored
            if (i_keypad_freq_wr) begin
                nxt_st.freq_local = i_keypad_freq;
            end
            if (i_keypad_stop_press) begin
                nxt_st.run = 1'b0;
            end else if (i_keypad_run_press) begin
                if (start[1]) begin
                    nxt_st.run = 1'b1;
                    nxt_st.reverse_run_input = start[0];
                end
            end else if (i_opt_fwd_key && st_ff.src != RCSS_SRC_KEY_REV) begin
                nxt_st.run = 1'b1;
                nxt_st.reverse_run_input = 1'b0;
            end else if (i_opt_rev_key && st_ff.src != RCSS_SRC_KEY_FWD) begin
                nxt_st.run = 1'b1;
                nxt_st.reverse_run_input = 1'b1;
            end
        end else if (i_link_operation) begin
            nxt_st.run = i_link_run_fwd ^ i_link_run_rev;
            nxt_st.reverse_run_input = i_link_run_rev;
        end else if (i_run_cmd2_select || st_ff.src == RCSS_SRC_TERMINAL) begin
            nxt_st.run = i_forward_run_input ^ i_reverse_run_input;
            nxt_st.reverse_run_input = i_reverse_run_input;
        end else begin
            if (i_keypad_stop_press) begin
                nxt_st.run = 1'b0;
            end else if (i_keypad_run_press && start[1]) begin
                nxt_st.run = 1'b1;
                nxt_st.reverse_run_input = start[0];
            end
        end

        nxt_st.freq_out = (nxt_st.mode == RCSS_MODE_LOCAL) ? nxt_st.freq_local
                                                           : i_remote_freq;

        // register port
        if (i_wr) begin
            if (i_addr == `RCSS_ADDR_SRC) begin
                nxt_st.src = rcss_src_t'(i_wdata[1:0]);
            end
            for (int k = 0; k < NT; k++) begin
                if (i_addr == (`RCSS_ADDR_ASSIGN0 + 8'(4 * k))) begin
                    nxt_st.assign_code[k] = i_wdata[7:0];
                end
            end
        end
        if (i_rd) begin
            if (i_addr == `RCSS_ADDR_SRC) begin
                nxt_st.rdata = {30'h0, st_ff.src};
            end else if (i_addr == `RCSS_ADDR_STATUS) begin
                nxt_st.rdata[`RCSS_STAT_LOCAL]  = (st_ff.mode == RCSS_MODE_LOCAL);
                nxt_st.rdata[`RCSS_STAT_RUN]    = st_ff.run;
                nxt_st.rdata[`RCSS_STAT_REV]    = st_ff.reverse_run_input;
                nxt_st.rdata[`RCSS_STAT_SEL_IN] = sel_in;
            end else if (i_addr[1:0] == 2'h0 && i_addr >= `RCSS_ADDR_ASSIGN0 &&
                         i_addr < `RCSS_ADDR_STATUS) begin
                nxt_st.rdata = {24'h0, st_ff.assign_code[word_index(i_addr) - 8'h01]};
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            st_ff      <= '0;
            st_ff.mode <= RCSS_MODE_REMOTE;
            st_ff.src  <= rcss_src_t'(`RCSS_RST_SRC);
            for (int k = 0; k < NT; k++) begin
                st_ff.assign_code[k] <= `RCSS_RST_ASSIGN;
            end
            st_ff.assign_code[`RCSS_TERM_T5_INDEX] <= `RCSS_RST_ASSIGN_T5;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata                 = st_ff.rdata;
    assign o_run_cmd               = st_ff.run;
    assign o_run_reverse           = st_ff.reverse_run_input;
    assign o_freq_cmd              = st_ff.freq_out;
    assign o_remote_mode_indicator = (st_ff.mode == RCSS_MODE_REMOTE);
    assign o_local_mode_indicator  = (st_ff.mode == RCSS_MODE_LOCAL);

    // checks
    logic is_local;
    logic stay_local;
    logic quiet;
    assign is_local   = (st_ff.mode == RCSS_MODE_LOCAL);
    assign stay_local = is_local && (nxt_st.mode == RCSS_MODE_LOCAL);
    assign quiet      = !sel_rise && !sel_fall && !toggle_fire;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    AST_SEL_RISE_LOCAL:
    assert property (sel_rise |=> o_local_mode_indicator && !o_remote_mode_indicator)
        else $error("select rise did not enter local mode");

    AST_SEL_FALL_REMOTE:
    assert property (sel_fall |=> o_remote_mode_indicator)
        else $error("select fall did not return to remote mode");

    AST_TOGGLE_IGNORED:
    assert property (sel_in && st_ff.sel_prev && toggle_fire |=> $stable(o_local_mode_indicator))
        else $error("toggle key acted while select input active");

    AST_TOGGLE_FLIPS:
    assert property (toggle_fire && !sel_in && !st_ff.sel_prev
                     |=> o_local_mode_indicator != $past(o_local_mode_indicator))
        else $error("toggle key hold did not flip the mode");

    AST_FREQ_INHERIT:
    assert property (enter_local |=> o_freq_cmd == $past(i_remote_freq) ##1
                     (o_freq_cmd == $past(o_freq_cmd) || $past(i_keypad_freq_wr) || !is_local))
        else $error("local frequency not inherited from remote");

    AST_CONFLICT_STOP:
    assert property (enter_local && st_ff.run && st_ff.reverse_run_input && st_ff.src == RCSS_SRC_KEY_FWD
                     |=> !o_run_cmd)
        else $error("conflicting direction not stopped at changeover");

    AST_RUN_CARRIED:
    assert property (enter_local && st_ff.run && st_ff.src == RCSS_SRC_KEY_TERM_DIR
                     |=> o_run_cmd && o_run_reverse == $past(o_run_reverse))
        else $error("run not carried over to local mode");

    AST_LOCAL_FWD_ONLY:
    assert property (stay_local && st_ff.src == RCSS_SRC_KEY_FWD && i_keypad_run_press
                     && !i_keypad_stop_press |=> o_run_cmd && !o_run_reverse)
        else $error("forward-only run press gave wrong direction");

    AST_LOCAL_REV_ONLY:
    assert property (stay_local && st_ff.src == RCSS_SRC_KEY_REV && i_keypad_run_press
                     && !i_keypad_stop_press |=> o_run_cmd && o_run_reverse)
        else $error("reverse-only run press gave wrong direction");

    AST_LOCAL_STOP:
    assert property (stay_local && i_keypad_stop_press |=> !o_run_cmd)
        else $error("stop press did not stop the motor in local mode");

    AST_OPT_REV_DISABLED:
    assert property (stay_local && st_ff.src == RCSS_SRC_KEY_FWD && !st_ff.run
                     && i_opt_rev_key && !i_opt_fwd_key && !i_keypad_run_press |=> !o_run_cmd)
        else $error("reverse key not disabled at source 2");

    AST_REMOTE_TERMINAL:
    assert property (!is_local && quiet && !i_link_operation && st_ff.src == RCSS_SRC_TERMINAL
                     && i_forward_run_input && !i_reverse_run_input
                     |=> o_run_cmd && !o_run_reverse)
        else $error("remote terminal command not followed");

    AST_LOCAL_IGNORES_LINK:
    assert property (stay_local && quiet && !i_keypad_run_press && !i_keypad_stop_press
                     && !i_opt_fwd_key && !i_opt_rev_key |=> $stable(o_run_cmd))
        else $error("local mode run changed without keypad");

    COV_ENTER_LOCAL:  cover property (sel_rise ##1 o_local_mode_indicator);
    COV_TOGGLE:       cover property (toggle_fire && !sel_in);
    COV_CONFLICT:     cover property (enter_local && st_ff.run && st_ff.reverse_run_input);
    COV_CARRY:        cover property (enter_local && st_ff.run ##1 o_run_cmd);
endmodule : rcss_top

// [testbench/rcss_keypad_model.sv]
`timescale 1ns/10ps

module rcss_keypad_model (
    input  wire logic       i_sys_clk,     // system clock
    input  wire logic       i_reset,       // synchronous reset, active high
    input  wire logic [2:0] i_key_req,     // 1 run, 2 stop, 3 forward, 4 reverse
    input  wire logic       i_hold,        // hold the toggle key down
    output logic            o_run_press,   // run key pulse
    output logic            o_stop_press,  // stop key pulse
    output logic            o_fwd_key,     // optional forward key pulse
    output logic            o_rev_key,     // optional reverse key pulse
    output logic            o_toggle_key   // toggle key level
);
    // one pulse per request cycle, keys released otherwise
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_run_press  <= 1'b0;
            o_stop_press <= 1'b0;
            o_fwd_key    <= 1'b0;
            o_rev_key    <= 1'b0;
            o_toggle_key <= 1'b0;
        end else begin
            o_run_press  <= (i_key_req == 3'h1);
            o_stop_press <= (i_key_req == 3'h2);
            o_fwd_key    <= (i_key_req == 3'h3);
            o_rev_key    <= (i_key_req == 3'h4);
            o_toggle_key <= i_hold;
        end
    end
endmodule : rcss_keypad_model

// [testbench/rcss_top_test.sv]
`timescale 1ns/10ps

module rcss_top_test;
    import rcss_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0, rd = 1'b0;
    logic [31:0] rdata;
    logic [6:0]  term = 7'h00;
    logic        fwd_in = 1'b0, rev_in = 1'b0, run2 = 1'b0;
    logic        link_op = 1'b0, link_fwd = 1'b0, link_rev = 1'b0;
    logic [15:0] rfreq = 16'h0000;
    logic [2:0]  key_req = 3'h0;
    logic        hold = 1'b0;
    logic        k_run, k_stop, k_fwd, k_rev, k_tog;
    logic        run_cmd, run_rev, remote_ind, local_ind;
    logic        kf_wr = 1'b0;
    logic [15:0] kf = 16'h0000;
    logic [15:0] freq;
    int          err_count = 0;
    int          check_count = 0;
    int          s;

    always #12.5 sys_clk = ~sys_clk;

    rcss_keypad_model kp (.i_sys_clk(sys_clk), .i_reset(reset), .i_key_req(key_req),
        .i_hold(hold), .o_run_press(k_run), .o_stop_press(k_stop), .o_fwd_key(k_fwd),
        .o_rev_key(k_rev), .o_toggle_key(k_tog));

    rcss_top #(.FW(16), .HOLD_CYCLES(8)) uut (.i_sys_clk(sys_clk), .i_reset(reset),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_general_input_terminal(term), .i_forward_run_input(fwd_in),
        .i_reverse_run_input(rev_in), .i_run_cmd2_select(run2), .i_link_operation(link_op),
        .i_link_run_fwd(link_fwd), .i_link_run_rev(link_rev), .i_remote_freq(rfreq),
        .i_keypad_run_press(k_run), .i_keypad_stop_press(k_stop), .i_keypad_freq_wr(kf_wr),
        .i_keypad_freq(kf), .i_opt_fwd_key(k_fwd), .i_opt_rev_key(k_rev),
        .i_opt_toggle_key(k_tog), .o_run_cmd(run_cmd), .o_run_reverse(run_rev),
        .o_freq_cmd(freq), .o_remote_mode_indicator(remote_ind),
        .o_local_mode_indicator(local_ind));

    task results;
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle

    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    task key(input logic [2:0] k);
        @(posedge sys_clk);
        key_req <= k;
        @(posedge sys_clk);
        key_req <= 3'h0;
        settle();
    endtask : key

    task out(input logic run, input logic reverse_run_input);
        chk({30'h0, run_cmd, run_rev}, {30'h0, run, reverse_run_input});
    endtask : out

    task hold_toggle;
        @(posedge sys_clk);
        hold <= 1'b1;
        repeat (14) @(posedge sys_clk);
        hold <= 1'b0;
        settle();
    endtask : hold_toggle

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        settle();
        chk({remote_ind, local_ind}, 2'b10);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h14, 32'h23);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h40, 32'h0);
        // remote, source 0: keypad run, terminal direction
        @(posedge sys_clk);
        fwd_in <= 1'b1;
        key(3'h1);
        out(1'b1, 1'b0);
        key(3'h2);
        @(posedge sys_clk);
        fwd_in <= 1'b0;
        rev_in <= 1'b1;
        key(3'h1);
        out(1'b1, 1'b1);
        key(3'h2);
        @(posedge sys_clk);
        rev_in <= 1'b0;
        for (s = 2; s < 4; s++) begin
            wr_reg(8'h00, s);
            key(3'h1);
            out(1'b1, s == 3);
            key(3'h2);
            // stop keeps the last direction
            out(1'b0, s == 3);
        end
        wr_reg(8'h00, 32'h1);
        fwd_in <= 1'b1;
        settle();
        out(1'b1, 1'b0);
        key(3'h2);
        out(1'b1, 1'b0);
        @(posedge sys_clk);
        fwd_in <= 1'b0;
        settle();
        out(1'b0, 1'b0);
        wr_reg(8'h00, 32'h0);
        link_op <= 1'b1;
        link_rev <= 1'b1;
        settle();
        out(1'b1, 1'b1);
        @(posedge sys_clk);
        link_fwd <= 1'b1;
        link_rev <= 1'b0;
        settle();
        out(1'b1, 1'b0);
        @(posedge sys_clk);
        link_op <= 1'b0;
        link_fwd <= 1'b0;
        run2 <= 1'b1;
        rev_in <= 1'b1;
        settle();
        out(1'b1, 1'b1);
        @(posedge sys_clk);
        rev_in <= 1'b0;
        settle();
        out(1'b0, 1'b0);
        @(posedge sys_clk);
        run2 <= 1'b0;
        // changeover while running forward at source 2
        wr_reg(8'h00, 32'h2);
        rfreq <= 16'h1234;
        key(3'h1);
        @(posedge sys_clk);
        term[4] <= 1'b1;
        settle();
        chk({remote_ind, local_ind}, 2'b01);
        out(1'b1, 1'b0);
        chk(freq, 16'h1234);
        rd_chk(8'h20, 32'hB);
        @(posedge sys_clk);
        rfreq <= 16'h5555;
        link_op <= 1'b1;
        link_rev <= 1'b1;
        settle();
        out(1'b1, 1'b0);
        chk(freq, 16'h1234);
        @(posedge sys_clk);
        link_op <= 1'b0;
        link_rev <= 1'b0;
        kf_wr <= 1'b1;
        kf <= 16'h0ABC;
        @(posedge sys_clk);
        kf_wr <= 1'b0;
        settle();
        chk(freq, 16'h0ABC);
        key(3'h4);
        out(1'b1, 1'b0);
        key(3'h2);
        out(1'b0, 1'b0);
        wr_reg(8'h00, 32'h3);
        key(3'h3);
        out(1'b0, 1'b0);
        key(3'h1);
        out(1'b1, 1'b1);
        key(3'h2);
        hold_toggle();
        chk(local_ind, 1'b1);
        wr_reg(8'h00, 32'h0);
        rev_in <= 1'b1;
        key(3'h1);
        out(1'b1, 1'b1);
        key(3'h3);
        out(1'b1, 1'b0);
        key(3'h2);
        out(1'b0, 1'b0);
        key(3'h4);
        out(1'b1, 1'b1);
        key(3'h2);
        @(posedge sys_clk);
        term[4] <= 1'b0;
        settle();
        chk(remote_ind, 1'b1);
        // reverse running meets forward-only local
        key(3'h1);
        wr_reg(8'h00, 32'h2);
        term[4] <= 1'b1;
        settle();
        out(1'b0, 1'b1);
        @(posedge sys_clk);
        term[4] <= 1'b0;
        rev_in <= 1'b0;
        settle();
        hold_toggle();
        chk({remote_ind, local_ind}, 2'b01);
        hold_toggle();
        chk({remote_ind, local_ind}, 2'b10);
        // select function also assigned to terminal one
        wr_reg(8'h04, 32'h23);
        rd_chk(8'h04, 32'h23);
        @(posedge sys_clk);
        term[0] <= 1'b1;
        settle();
        chk({remote_ind, local_ind}, 2'b01);
        results();
    end

    initial begin
        #400000;
        err_count++;
        results();
    end
endmodule : rcss_top_test
